// File: include/rtcv_pkg.sv
// shared constants and types for the time/alarm value window block
package rtcv_pkg;

    // register byte offsets on the bus
    localparam int          RTCV_AW          = 8;
    localparam logic [7:0]  TIME_CTRL_OFS    = 8'h00;
    localparam logic [7:0]  ALARM_CTRL_OFS   = 8'h04;
    localparam logic [7:0]  TIME_HIGH_OFS    = 8'h08;
    localparam logic [7:0]  TIME_LOW_OFS     = 8'h0C;
    localparam logic [7:0]  ALARM_HIGH_OFS   = 8'h10;
    localparam logic [7:0]  ALARM_LOW_OFS    = 8'h14;

    // control field positions and reset values
    localparam int          PTR_LSB          = 0;
    localparam int          PTR_MSB          = 1;
    localparam int          UNLOCK_BIT       = 5;
    localparam logic [1:0]  PTR_RESET        = 2'h0;
    localparam logic [1:0]  PTR_FLOOR        = 2'h0;
    localparam logic [1:0]  PTR_STEP         = 2'h1;
    localparam logic        UNLOCK_RESET     = 1'b0;

    // value slots: slot index is {pointer, high_byte_select}
    localparam int          TIME_SLOTS       = 4;
    localparam int          ALARM_SLOTS      = 6;
    localparam logic [2:0]  TIME_SLOT_LIMIT  = 3'h4;
    localparam logic [2:0]  ALARM_SLOT_LIMIT = 3'h6;

    // implemented bits per slot: seconds, minutes, hours, weekday
    localparam logic [7:0]  TIME_SLOT_MASK [0:3] = '{8'h7F, 8'h7F, 8'h3F, 8'h07};
    // seconds, minutes, hours, weekday, day, month
    localparam logic [7:0]  ALARM_SLOT_MASK [0:5] =
        '{8'h7F, 8'h7F, 8'h3F, 8'h07, 8'h3F, 8'h1F};
    // slots that only take writes while the unlock bit is set
    localparam logic [3:0]  TIME_SLOT_LOCKED  = 4'hF;
    localparam logic [5:0]  ALARM_SLOT_LOCKED = 6'h3C;

    // bus constants
    localparam logic [23:0] RDATA_PAD        = 24'h000000;
    localparam logic [31:0] RDATA_RESET      = 32'h00000000;
    localparam logic [7:0]  BYTE_ZERO        = 8'h00;
    localparam logic        RESP_OKAY        = 1'b0;

    // bus phase state, one-hot
    typedef enum logic [2:0] {
        BUS_IDLE  = 3'b001,
        BUS_WRITE = 3'b010,
        BUS_READ  = 3'b100
    } rtcv_bus_state_t;

    // captured address phase
    typedef struct packed {
        logic               write;
        logic [RTCV_AW-1:0] addr;
    } rtcv_req_t;

endpackage

// File: core/rtcv_window.sv
// register window slave for time and alarm BCD value fields
//
// The placing of the registers and the AHB-Lite register port were decided locally.
`timescale 1ns/1ps

module rtcv_window
    import rtcv_pkg::*;
(
    // clock and reset
    input  wire logic        CORE_CLK,
    input  wire logic        ARST_N,
    // ahb-lite slave
    input  wire logic        HSEL,
    input  wire logic [31:0] HADDR,
    input  wire logic [1:0]  HTRANS,
    input  wire logic        HWRITE,
    input  wire logic [2:0]  HSIZE,
    input  wire logic [31:0] HWDATA,
    input  wire logic        HREADY,
    output logic             HREADYOUT,
    output logic [31:0]      HRDATA,
    output logic             HRESP
);

    rtcv_bus_state_t state_q;
    rtcv_req_t       req_q;
    logic            hready_q;
    logic [31:0]     hrdata_q;
    logic [1:0]      tptr_q;
    logic [1:0]      aptr_q;
    logic            unlock_q;
    logic [7:0]      time_q  [0:TIME_SLOTS-1];
    logic [7:0]      alarm_q [0:ALARM_SLOTS-1];
    logic            accept;
    logic            wr_commit;
    logic            rd_commit;
    logic            hit_tctrl;
    logic            hit_actrl;
    logic            hit_thi;
    logic            hit_tlo;
    logic            hit_ahi;
    logic            hit_alo;
    logic [2:0]      tslot;
    logic [2:0]      aslot;
    logic            time_wr;
    logic            alarm_wr;
    logic [7:0]      rd_byte;

    // only single word transfers are expected; size is not checked
    assign accept    = HSEL & HTRANS[1] & HREADY;
    assign wr_commit = (state_q == BUS_WRITE);
    assign rd_commit = (state_q == BUS_READ);

    // decode of the captured address; upper address bits alias
    assign hit_tctrl = (req_q.addr == TIME_CTRL_OFS);
    assign hit_actrl = (req_q.addr == ALARM_CTRL_OFS);
    assign hit_thi   = (req_q.addr == TIME_HIGH_OFS);
    assign hit_tlo   = (req_q.addr == TIME_LOW_OFS);
    assign hit_ahi   = (req_q.addr == ALARM_HIGH_OFS);
    assign hit_alo   = (req_q.addr == ALARM_LOW_OFS);

    // slot = {pointer, high byte}: 00 -> min/sec, 01 -> weekday_digit/hour, 10 -> month/day
    assign tslot = {tptr_q, hit_thi};
    assign aslot = {aptr_q, hit_ahi};

    // write enables; unmapped slots (time pointer 10 or 11, alarm pointer 11) take nothing
    assign time_wr = wr_commit & (hit_thi | hit_tlo) & (tslot < TIME_SLOT_LIMIT)
                   & unlock_q;
    assign alarm_wr = wr_commit & (hit_ahi | hit_alo) & (aslot < ALARM_SLOT_LIMIT);

    // bus phase tracking: writes finish at once, reads take one wait state
    // so a read right after a write sees the freshly written value
    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            state_q  <= BUS_IDLE;
            hready_q <= 1'b1;
            req_q    <= '0;
        end else begin
            unique case (state_q)
                BUS_IDLE, BUS_WRITE: begin
                    if (accept) begin
                        req_q.write <= HWRITE;
                        req_q.addr  <= HADDR[RTCV_AW-1:0];
                        if (HWRITE) begin
                            state_q <= BUS_WRITE;
                        end else begin
                            state_q  <= BUS_READ;
                            hready_q <= 1'b0;
                        end
                    end else begin
                        state_q <= BUS_IDLE;
                    end
                end
                BUS_READ: begin
                    state_q  <= BUS_IDLE;
                    hready_q <= 1'b1;
                end
            endcase
        end
    end

    // read data is sampled in the wait cycle, then held until the next read
    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            hrdata_q <= RDATA_RESET;
        end else if (rd_commit) begin
            hrdata_q <= {RDATA_PAD, rd_byte};
        end
    end

    // read multiplexer; unimplemented slots and addresses read zero
    always_comb begin
        rd_byte = BYTE_ZERO;
        if (hit_tctrl) begin
            rd_byte[PTR_MSB:PTR_LSB] = tptr_q;
            rd_byte[UNLOCK_BIT]      = unlock_q;
        end else if (hit_actrl) begin
            rd_byte[PTR_MSB:PTR_LSB] = aptr_q;
        end else if ((hit_thi | hit_tlo) && (tslot < TIME_SLOT_LIMIT)) begin
            rd_byte = time_q[tslot[1:0]];
        end else if ((hit_ahi | hit_alo) && (aslot < ALARM_SLOT_LIMIT)) begin
            rd_byte = alarm_q[aslot];
        end
    end

    // time pointer and unlock; every high byte access steps the pointer down until it reaches 00
    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            tptr_q   <= PTR_RESET;
            unlock_q <= UNLOCK_RESET;
        end else if (wr_commit && hit_tctrl) begin
            tptr_q   <= HWDATA[PTR_MSB:PTR_LSB];
            unlock_q <= HWDATA[UNLOCK_BIT];
        end else if ((wr_commit || rd_commit) && hit_thi && (tptr_q != PTR_FLOOR)) begin
            tptr_q <= tptr_q - PTR_STEP;
        end
    end

    // alarm pointer, same stepping, stops at 00
    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            aptr_q <= PTR_RESET;
        end else if (wr_commit && hit_actrl) begin
            aptr_q <= HWDATA[PTR_MSB:PTR_LSB];
        end else if ((wr_commit || rd_commit) && hit_ahi && (aptr_q != PTR_FLOOR)) begin
            aptr_q <= aptr_q - PTR_STEP;
        end
    end

    // value slots carry no reset: contents are unknown until written
    genvar g;
    generate
        for (g = 0; g < TIME_SLOTS; g++) begin : g_time
            always_ff @(posedge CORE_CLK) begin
                if (time_wr && (tslot == g) && (unlock_q || !TIME_SLOT_LOCKED[g])) begin
                    // masks hold field widths; unused bits never store
                    time_q[g] <= HWDATA[7:0] & TIME_SLOT_MASK[g];
                end
            end
        end
        for (g = 0; g < ALARM_SLOTS; g++) begin : g_alarm
            always_ff @(posedge CORE_CLK) begin
                if (alarm_wr && (aslot == g) && (unlock_q || !ALARM_SLOT_LOCKED[g])) begin
                    // digits are stored masked to field width; range is software's job
                    alarm_q[g] <= HWDATA[7:0] & ALARM_SLOT_MASK[g];
                end
            end
        end
    endgenerate

    // ready and read data straight from flops; HRESP tied to okay
    assign HREADYOUT = hready_q;
    assign HRDATA    = hrdata_q;
    assign HRESP     = RESP_OKAY;

endmodule

// File: tb/rtcv_monitor.sv
// bus-port assertions for the time and alarm value window
`timescale 1ns/1ps
module rtcv_monitor
    import rtcv_pkg::*;
(
    // watched ports
    input wire logic        CORE_CLK,
    input wire logic        ARST_N,
    input wire logic        HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0]  HTRANS,
    input wire logic        HWRITE,
    input wire logic        HREADY,
    input wire logic        HREADYOUT,
    input wire logic [31:0] HRDATA,
    input wire logic        HRESP
);
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!ARST_N);
    // address phase accepted by the slave
    wire logic tk = HSEL && HTRANS[1] && HREADY;
    sequence s_rd(a); tk && !HWRITE && HADDR[7:0] == a; endsequence
    sequence s_one_wait; !HREADYOUT ##1 HREADYOUT; endsequence
    a_read_wait: assert property (tk && !HWRITE |=> s_one_wait)
        else $error("read wait not one cycle");
    a_write_nowait: assert property (tk && HWRITE |=> HREADYOUT)
        else $error("write stalled");
    a_resp_okay: assert property (HRESP == RESP_OKAY)
        else $error("response not okay");
    a_rdata_pad: assert property (HRDATA[31:8] == RDATA_PAD)
        else $error("upper read bits set");
    // read data only moves when a read completes
    a_rdata_hold: assert property (HREADYOUT && $past(HREADYOUT) |-> $stable(HRDATA))
        else $error("read data moved");
    a_sec_bit7: assert property (s_rd(TIME_LOW_OFS) |-> ##2 !HRDATA[7])
        else $error("seconds bit 7 set");
    a_alarm_bit7: assert property ((s_rd(ALARM_HIGH_OFS) or s_rd(ALARM_LOW_OFS))
        |-> ##2 !HRDATA[7]) else $error("alarm bit 7 set");
    a_unmapped_zero: assert property (tk && !HWRITE && HADDR[7:0] > ALARM_LOW_OFS
        |-> ##2 HRDATA == RDATA_RESET) else $error("unmapped read not zero");
endmodule
bind rtcv_window rtcv_monitor rtcv_monitor_inst (
    .CORE_CLK(CORE_CLK), .ARST_N(ARST_N), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
    .HWRITE(HWRITE), .HREADY(HREADY), .HREADYOUT(HREADYOUT), .HRDATA(HRDATA), .HRESP(HRESP)
);

// File: tb/tb_rtcv_window.sv
// self-checking bench: value window over the register bus
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin failures++; \
    $display("unexpected at %0t: got %h want %h", $time, (g), (e)); end end
module tb_rtcv_window
    import rtcv_pkg::*;
;
    localparam logic [7:0] TC = TIME_CTRL_OFS, AC = ALARM_CTRL_OFS, TH = TIME_HIGH_OFS;
    localparam logic [7:0] TL = TIME_LOW_OFS, AH = ALARM_HIGH_OFS, AL = ALARM_LOW_OFS;
    // bus and reset drive
    logic        CORE_CLK;
    logic        ARST_N     = 1'b0;
    logic [31:0] HADDR      = 32'h00000000;
    logic [1:0]  HTRANS     = 2'h0;
    logic        HWRITE     = 1'b0;
    logic [31:0] HWDATA     = 32'h00000000;
    logic        HREADYOUT;
    logic        HRESP;
    logic [31:0] HRDATA;
    logic [31:0] rd;
    int          failures   = 0;
    int          num_checks = 0;
    // hready loops back: this is the only slave
    rtcv_window rtcv_window_inst (
        .CORE_CLK(CORE_CLK), .ARST_N(ARST_N), .HSEL(1'b1), .HADDR(HADDR),
        .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA),
        .HREADY(HREADYOUT), .HREADYOUT(HREADYOUT), .HRDATA(HRDATA), .HRESP(HRESP)
    );
    initial begin
        CORE_CLK = 1'b0;
        forever #25 CORE_CLK = ~CORE_CLK;
    end
    // one transfer; ready is sampled at rising edges, signals move just after
    task bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        HADDR  <= {24'h000000, a};
        HWRITE <= w;
        HTRANS <= 2'h2;
        do @(posedge CORE_CLK); while (HREADYOUT !== 1'b1);
        HTRANS <= 2'h0;
        HWDATA <= {24'h000000, d};
        do @(posedge CORE_CLK); while (HREADYOUT !== 1'b1);
        rd = HRDATA;
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        bus(1'b1, a, d);
    endtask
    task rc(input logic [7:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00);
        `CHK(rd, {24'h000000, e})
    endtask
    task summarize();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // watchdog: the whole sequence needs about 130 cycles
    initial begin
        repeat (3000) @(posedge CORE_CLK);
        failures++;
        summarize();
    end
    initial begin
        repeat (20) @(posedge CORE_CLK);
        ARST_N <= 1'b1;
        @(posedge CORE_CLK);
        rc(TC, 8'h00);
        rc(AC, 8'h00);
        $display("test reset done");
        wr(TC, 8'h21);
        wr(TL, 8'hE3);
        wr(TH, 8'hFE);
        wr(TH, 8'hD9);
        wr(TL, 8'hB7);
        rc(TC, 8'h20);
        wr(TC, 8'h21);
        rc(TL, 8'h23);
        rc(TH, 8'h06);
        rc(TH, 8'h59);
        rc(TL, 8'h37);
        $display("test time done");
        // locked: writes dropped but the pointer still steps
        wr(TC, 8'h01);
        wr(TL, 8'h00);
        wr(TH, 8'h00);
        rc(TC, 8'h00);
        wr(TC, 8'h01);
        rc(TL, 8'h23);
        rc(TH, 8'h06);
        $display("test lock done");
        wr(TC, 8'h20);
        wr(AC, 8'h02);
        wr(AL, 8'hF1);
        wr(AH, 8'hF2);
        wr(AL, 8'hE0);
        wr(AH, 8'hFB);
        wr(AH, 8'hC5);
        wr(AL, 8'hA8);
        wr(AC, 8'h02);
        rc(AL, 8'h31);
        rc(AH, 8'h12);
        rc(AL, 8'h20);
        rc(AH, 8'h03);
        rc(AH, 8'h45);
        rc(AL, 8'h28);
        rc(AC, 8'h00);
        wr(TC, 8'h00);
        wr(AC, 8'h02);
        wr(AL, 8'h00);
        wr(AH, 8'h00);
        wr(AC, 8'h02);
        rc(AL, 8'h31);
        rc(AH, 8'h12);
        $display("test alarm done");
        wr(8'h18, 8'hFF);
        rc(8'h18, 8'h00);
        $display("test unmapped done");
        summarize();
    end
endmodule
